/* core/rx_line_status_flags.sv */
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "rx_lsr_cfg.svh"

module rx_line_status_flags #(
  parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        rxCharValid,
  input  wire logic [7:0]  rxCharData,
  input  wire logic        rxParityBit,
  output logic             irq
);

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // ============================================================
  // Parameter check
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256) begin : gBadDepth
    $error("rx_line_status_flags: FIFO_DEPTH must lie in 2..256");
  end

  // ============================================================
  // Reset release synchroniser
  logic rstMeta_ff;
  logic rstN_ff;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstMeta_ff <= 1'b0;
      rstN_ff    <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstN_ff    <= rstMeta_ff;
    end
  end

  // ============================================================
  // Declarations
  rx_status_pkg::state_t   state_ff;
  rx_status_pkg::state_t   nxt_state;
  rx_status_pkg::rx_char_t headChar;
  rx_status_pkg::rx_char_t inChar;
  logic [LW-1:0]        fifoLevel;
  logic                 fifoEmpty;
  logic                 fifoFull;
  logic                 pushReq;
  logic                 popReq;
  logic                 flushReq;
  logic                 addrTaken;
  logic [7:0]           addrOff;
  logic                 parityBad;
  logic                 overrunEvt;
  logic [7:0]           lineStatus;
  logic [2:0]           events;
  logic [2:0]           wrCtrl;

  // ============================================================
  // Functions

  // Parity check of one received character
  function automatic logic parityMismatch(
    input logic [7:0] data,
    input logic       parBit,
    input logic       enable,
    input logic       even
  );
    logic ones;
    ones = ^{data, parBit};
    parityMismatch = enable && (ones ^ !even);
  endfunction

  // Word offset decode of a byte address
  function automatic logic [7:0] wordOff(input logic [31:0] addr);
    wordOff = {addr[7:2], 2'b00};
  endfunction

  // Widen a small field to a bus word
  function automatic logic [31:0] toWord(input logic [7:0] v);
    toWord = {24'h000000, v};
  endfunction

  // ============================================================
  // Receive FIFO; one-entry holding register when FIFO mode is off
  rx_char_fifo #(
    .WIDTH      (9),
    .DEPTH      (FIFO_DEPTH)
  ) rx_char_fifo_i (
    .clk        (clk_sys),
    .rstN       (rstN_ff),
    .push       (pushReq),
    .pushData   (inChar),
    .pop        (popReq),
    .flush      (flushReq),
    .singleMode (!state_ff.ctrl[`CTRL_FIFO_BIT]),
    .headData   (headChar),
    .empty      (fifoEmpty),
    .full       (fifoFull),
    .level      (fifoLevel)
  );

  // ============================================================
  // Receive path

  // Parity check against configured mode
  assign parityBad = parityMismatch(rxCharData, rxParityBit,
                                    state_ff.ctrl[`CTRL_PAR_EN_BIT],
                                    state_ff.ctrl[`CTRL_EVEN_BIT]); // RULE1

  // Character with its parity flag, as queued
  assign inChar.data = rxCharData;
  assign inChar.perr = parityBad; // RULE1

  // Full FIFO refuses the new byte and raises overrun
  assign overrunEvt = rxCharValid && fifoFull; // RULE3
  assign pushReq    = rxCharValid && !fifoFull; // RULE5

  // ============================================================
  // Line status as seen by software
  always_comb begin
    lineStatus = 8'h00;
    lineStatus[`STAT_READY_BIT]   = !fifoEmpty; // RULE6 RULE7
    lineStatus[`STAT_OVERRUN_BIT] = state_ff.overrun;
    lineStatus[`STAT_PARITY_BIT]  = !fifoEmpty && headChar.perr; // RULE2 RULE9
  end

  // ============================================================
  // Interrupt events
  always_comb begin
    events = 3'h0;
    events[`IRQ_DATA_BIT]    = pushReq;
    events[`IRQ_OVERRUN_BIT] = overrunEvt;
    events[`IRQ_PARITY_BIT]  = pushReq && parityBad;
  end

  // ============================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = state_ff.rdData;
  assign irq       = |(state_ff.irqStat & state_ff.irqMask);

  // Address phase accepted this edge
  assign addrTaken = hsel && htrans[1] && hready;
  assign addrOff   = wordOff(haddr);

  // Control word as written in the data phase
  assign wrCtrl = {hwdata[`CTRL_EVEN_BIT],
                   hwdata[`CTRL_PAR_EN_BIT],
                   hwdata[`CTRL_FIFO_BIT]};

  // ============================================================
  // Next state
  always_comb begin
    nxt_state = state_ff;
    popReq    = 1'b0;
    flushReq  = 1'b0;

    // Latch the address phase for the data phase
    nxt_state.phase.active = addrTaken;
    nxt_state.phase.write  = hwrite;
    nxt_state.phase.off    = addrOff;

    // Read side effects and data, taken at the address phase
    if (addrTaken && !hwrite) begin
      unique case (addrOff)
        `OFF_RX_DATA: begin
          nxt_state.rdData = toWord(headChar.data);
          popReq           = !fifoEmpty;
        end
        `OFF_LINE_STATUS: begin
          nxt_state.rdData  = toWord(lineStatus);
          nxt_state.overrun = 1'b0; // RULE9
        end
        `OFF_RX_CTRL: begin
          nxt_state.rdData = toWord({5'h00, state_ff.ctrl});
        end
        `OFF_IRQ_STATUS: begin
          nxt_state.rdData = toWord({5'h00, state_ff.irqStat});
        end
        `OFF_IRQ_MASK: begin
          nxt_state.rdData = toWord({5'h00, state_ff.irqMask});
        end
        `OFF_RX_LEVEL: begin
          nxt_state.rdData = {{(32-LW){1'b0}}, fifoLevel};
        end
        `OFF_RX_SHIFT: begin
          nxt_state.rdData = toWord(state_ff.shiftReg); // RULE4
        end
        default: begin
          nxt_state.rdData = 32'h00000000;
        end
      endcase
    end

    // Writes land in the data phase
    if (state_ff.phase.active && state_ff.phase.write) begin
      unique case (state_ff.phase.off)
        `OFF_RX_CTRL: begin
          nxt_state.ctrl = wrCtrl;
          flushReq = (wrCtrl[`CTRL_FIFO_BIT] != state_ff.ctrl[`CTRL_FIFO_BIT]);
        end
        `OFF_IRQ_STATUS: begin
          nxt_state.irqStat = state_ff.irqStat & ~hwdata[2:0];
        end
        `OFF_IRQ_MASK: begin
          nxt_state.irqMask = hwdata[2:0];
        end
        default: begin
        end
      endcase
    end

    // New character always overwrites the shift register
    if (rxCharValid) begin
      nxt_state.shiftReg = rxCharData; // RULE4
    end

    // Overrun set wins over the read clear
    if (overrunEvt) begin
      nxt_state.overrun = 1'b1; // RULE3
    end

    // Events set wins over write-one-to-clear
    nxt_state.irqStat = nxt_state.irqStat | events;
  end

  // ============================================================
  // State register; flags start clear
  always_ff @(posedge clk_sys or negedge rstN_ff) begin
    if (!rstN_ff) begin
      state_ff         <= '0;
      state_ff.overrun <= 1'b0; // RULE8
      state_ff.ctrl    <= `CTRL_RESET;
      state_ff.irqStat <= `IRQ_STAT_RESET;
      state_ff.irqMask <= `IRQ_MASK_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule

`default_nettype wire

/* common/rx_lsr_cfg.svh */
// Contract
// RULE1: Flag a parity error when received parity does not match the configured parity.
// RULE2: In FIFO mode the parity flag shows the character at the FIFO head.
// RULE3: Flag an overrun when a character completes while the receive FIFO is full.
// RULE4: On an overrun the new character overwrites the receive shift register.
// RULE5: On an overrun the shift register byte is not pushed into the full FIFO.
// RULE6: Data-ready is high while the holding register or FIFO holds a character.
// RULE7: Data-ready is low when nothing is held; low is its default.
// RULE8: Parity and overrun flags are zero after reset until an error occurs.
// RULE9: Reading line status clears overrun; parity follows the next head character.
`ifndef RX_STATUS_CFG_SVH
`define RX_STATUS_CFG_SVH

// ============================================================
// Register byte offsets
`define OFF_RX_DATA      8'h00
`define OFF_LINE_STATUS  8'h04
`define OFF_RX_CTRL      8'h08
`define OFF_IRQ_STATUS   8'h0C
`define OFF_IRQ_MASK     8'h10
`define OFF_RX_LEVEL     8'h14
`define OFF_RX_SHIFT     8'h18

// ============================================================
// Line status bit positions
`define STAT_READY_BIT   0
`define STAT_OVERRUN_BIT 1
`define STAT_PARITY_BIT  2

// ============================================================
// Control bit positions and reset value
`define CTRL_FIFO_BIT    0
`define CTRL_PAR_EN_BIT  1
`define CTRL_EVEN_BIT    2
`define CTRL_RESET       3'h0

// ============================================================
// Interrupt event bit positions and reset values
`define IRQ_DATA_BIT     0
`define IRQ_OVERRUN_BIT  1
`define IRQ_PARITY_BIT   2
`define IRQ_STAT_RESET   3'h0
`define IRQ_MASK_RESET   3'h0

// ============================================================
// Receive FIFO geometry
`define RX_FIFO_DEPTH    128
`define RX_CHAR_BITS     8

`endif

/* common/rx_lsr_pkg.sv */
`default_nettype none

package rx_status_pkg;

  // ============================================================
  // FIFO entry: parity flag travels with its character
  typedef struct packed {
    logic       perr;
    logic [7:0] data;
  } rx_char_t;

  // ============================================================
  // Latched AHB address phase
  typedef struct packed {
    logic       active;
    logic       write;
    logic [7:0] off;
  } ahb_phase_t;

  // ============================================================
  // Whole state of the status block
  typedef struct packed {
    ahb_phase_t  phase;
    logic [31:0] rdData;
    logic        overrun;
    logic [7:0]  shiftReg;
    logic [2:0]  ctrl;
    logic [2:0]  irqStat;
    logic [2:0]  irqMask;
  } state_t;

endpackage

`default_nettype wire

/* core/rx_char_fifo.sv */
`timescale 1ns/1ns
`default_nettype none

module rx_char_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 128,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] pushData,
  input  wire logic             pop,
  input  wire logic             flush,
  input  wire logic             singleMode,
  output logic      [WIDTH-1:0] headData,
  output logic                  empty,
  output logic                  full,
  output logic      [AW:0]      level
);

  // ============================================================
  // Geometry check
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gBadDepth
    $error("rx_char_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rdPtr;
    logic [AW-1:0]               wrPtr;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t state_ff;
  fifo_state_t nxt_state;
  logic        doPush;
  logic        doPop;

  // ============================================================
  // Flags; single mode acts as a one-entry holding register
  assign empty    = (state_ff.count == '0);
  assign full     = singleMode ? !empty : (state_ff.count == (AW+1)'(DEPTH));
  assign level    = state_ff.count;
  assign headData = state_ff.mem[state_ff.rdPtr];
  assign doPush   = push && !full;
  assign doPop    = pop && !empty;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    if (flush) begin
      nxt_state.rdPtr = '0;
      nxt_state.wrPtr = '0;
      nxt_state.count = '0;
    end else begin
      if (doPush) begin
        nxt_state.mem[state_ff.wrPtr] = pushData;
        nxt_state.wrPtr = state_ff.wrPtr + AW'(1);
      end
      if (doPop) begin
        nxt_state.rdPtr = state_ff.rdPtr + AW'(1);
      end
      nxt_state.count = state_ff.count + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule

`default_nettype wire

/* testbench/rx_char_source.sv */
`timescale 1ns/1ns
`default_nettype none

module rx_char_source (
  input  wire logic       clk_sys,
  output logic            rxCharValid,
  output logic      [7:0] rxCharData,
  output logic            rxParityBit
);
  // ==========================================
  // Idle lines show the inverse of the last char
  initial begin
    rxCharValid = 1'b0;
    rxCharData  = 8'hA5;
    rxParityBit = 1'b0;
  end

  // One-cycle char pulse, then lines go stale
  task automatic send(input logic [7:0] d, input logic p);
    rxCharValid <= 1'b1;
    rxCharData  <= d;
    rxParityBit <= p;
    @(posedge clk_sys);
    rxCharValid <= 1'b0;
    rxCharData  <= ~d;
    rxParityBit <= ~p;
  endtask
endmodule

`default_nettype wire

/* testbench/rx_lsr_properties.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rx_lsr_cfg.svh"

module rx_status_checker #(
  parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        rxCharValid,
  input wire logic [7:0]  rxCharData,
  input wire logic        rxParityBit,
  input wire logic        irq
);
  // ==========================================
  // Decoded address phases
  logic take;
  logic statRd;
  logic lvlRd;
  logic seenChar_ff;
  assign take   = hsel && htrans[1] && hready;
  assign statRd = take && !hwrite && haddr[7:0] == `OFF_LINE_STATUS;
  assign lvlRd = take && !hwrite && haddr[7:0] == `OFF_RX_LEVEL;

  // Any char since reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      seenChar_ff <= 1'b0;
    end else if (rxCharValid) begin
      seenChar_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // ==========================================
  // Properties
  property p_readyAfterChar;
    rxCharValid && !take ##1 statRd |=> hrdata[0];
  endproperty
  a_readyAfterChar: assert property (p_readyAfterChar) else $error("ready low after char");
  property p_levelMatchesReady;
    statRd && !rxCharValid ##1 !take && !rxCharValid ##1 lvlRd && !rxCharValid
      |=> (hrdata != 32'h0) == $past(hrdata[0]);
  endproperty
  a_levelMatchesReady: assert property (p_levelMatchesReady) else $error("ready vs level");
  property p_overrunReadClear;
    statRd && !rxCharValid ##1 !rxCharValid ##1 statRd && !rxCharValid |=> !hrdata[1];
  endproperty
  a_overrunReadClear: assert property (p_overrunReadClear) else $error("overrun kept");
  property p_quietAfterReset;
    !seenChar_ff && !rxCharValid && statRd |=> hrdata[2:1] == 2'b00;
  endproperty
  a_quietAfterReset: assert property (p_quietAfterReset) else $error("flag without char");
  property p_irqQuiet;
    !seenChar_ff |-> !irq;
  endproperty
  a_irqQuiet: assert property (p_irqQuiet) else $error("irq without event");
  property p_parityEmpty;
    statRd ##1 !hrdata[0] |-> !hrdata[2];
  endproperty
  a_parityEmpty: assert property (p_parityEmpty) else $error("parity with no head");
  property p_levelBound;
    lvlRd |=> hrdata <= 32'(FIFO_DEPTH);
  endproperty
  a_levelBound: assert property (p_levelBound) else $error("level above depth");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not OKAY");
endmodule

bind rx_line_status_flags rx_status_checker #(.FIFO_DEPTH(FIFO_DEPTH)) rx_status_checker_i (
  .clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hreadyout, .hresp, .hrdata, .rxCharValid, .rxCharData, .rxParityBit, .irq);

`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rx_lsr_cfg.svh"

module tb_top;
  logic        clk_sys, nrst, hsel, hwrite, hreadyout, hresp, irq;
  logic        rxCharValid, rxParityBit;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  rxCharData;
  logic [7:0]  q [4] = '{8'h01, 8'h03, 8'h07, 8'h0F};
  logic        bad [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic [31:0] statAfter [4] = '{32'h5, 32'h1, 32'h1, 32'h0};
  int          nMismatch, checks;

  rx_line_status_flags #(.FIFO_DEPTH(4)) rx_line_status_flags_i (
    .clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rxCharValid, .rxCharData,
    .rxParityBit, .irq);
  rx_char_source rx_char_source_i (.clk_sys, .rxCharValid, .rxCharData, .rxParityBit);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ==========================================
  // Bus and check tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      nMismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic put(input logic [7:0] d, input logic odd, input logic bd);
    rx_char_source_i.send(d, ^d ^ odd ^ bd);
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog
  initial begin
    #400000;
    nMismatch++;
    print_verdict;
  end

  // ==========================================
  // Test sequence
  initial begin
    nrst = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; nMismatch = 0; checks = 0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdchk(`OFF_LINE_STATUS, 32'h0);
    rdchk(`OFF_RX_LEVEL, 32'h0);
    rdchk(`OFF_RX_CTRL, 32'h0);
    rdchk(`OFF_IRQ_MASK, 32'h0);
    xfer(1'b1, 8'h20, 32'hFFFFFFFF);
    rdchk(8'h20, 32'h0);
    $display("reset test done");
    xfer(1'b1, `OFF_RX_CTRL, 32'h6);
    put(8'h55, 1'b0, 1'b0);
    rdchk(`OFF_LINE_STATUS, 32'h1);
    put(8'h33, 1'b0, 1'b0);
    rdchk(`OFF_LINE_STATUS, 32'h3);
    rdchk(`OFF_LINE_STATUS, 32'h1);
    rdchk(`OFF_RX_SHIFT, 32'h33);
    rdchk(`OFF_RX_DATA, 32'h55);
    rdchk(`OFF_LINE_STATUS, 32'h0);
    $display("holding overrun test done");
    xfer(1'b1, `OFF_IRQ_STATUS, 32'h7);
    put(8'h01, 1'b0, 1'b1);
    rdchk(`OFF_LINE_STATUS, 32'h5);
    rdchk(`OFF_IRQ_STATUS, 32'h5);
    xfer(1'b1, `OFF_IRQ_MASK, 32'h4);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk_sys);
    xfer(1'b1, `OFF_IRQ_STATUS, 32'h4);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk_sys);
    rdchk(`OFF_RX_DATA, 32'h01);
    rdchk(`OFF_LINE_STATUS, 32'h0);
    $display("parity irq test done");
    xfer(1'b1, `OFF_RX_CTRL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      put(q[i], 1'b1, bad[i]);
      @(posedge clk_sys); // Idle cycle between chars
    end
    put(8'h11, 1'b1, 1'b0);
    rdchk(`OFF_LINE_STATUS, 32'h3);
    rdchk(`OFF_RX_LEVEL, 32'h4);
    rdchk(`OFF_RX_SHIFT, 32'h11);
    for (int i = 0; i < 4; i++) begin
      rdchk(`OFF_RX_DATA, {24'h0, q[i]});
      rdchk(`OFF_LINE_STATUS, statAfter[i]);
    end
    $display("fifo overrun test done");
    print_verdict;
  end
endmodule

`default_nettype wire
